// file: hw/stap_pkg.sv
// Notes on behaviour
// (R1) Instruction capture loads 01 into low bits
// (R2) Instruction shift: TDI in, old bits out TDO
// (R3) New instruction acts only at instruction update
// (R4) Code 111 selects bypass path in data shift
// (R5) Code 100 captures pins, shifts boundary chain
// (R6) Non-pin boundary cells capture fixed default
// (R7) External test never blocks RAM input pins
// (R8) External test drives outputs at update falling
// (R9) External test captures pins on rising edge
// (R10) Code 001 captures and shifts identification word
// (R11) Identification instruction after power-up and reset state
// (R12) Code 010 floats outputs, shifts boundary chain
// (R13) Identification word: part, vendor, presence bit
// (R14) Controller holds inputs stable around capture
// (R15) Instruction register is three bits, MSB left
// (R16) Five TMS-high rising edges reach reset state
// (R17) Bypass register is one flip-flop
// (R18) Identification bit 0 leaves TDO first
// (R19) Private codes select bypass, no pin effect
// (R20) Standard sixteen-state TAP sequence on TCK rise
package stap_pkg;

    localparam int IR_W = 3;
    localparam logic [2:0] INSTR_EXTEST = 3'h0;
    localparam logic [2:0] INSTR_IDCODE = 3'h1;
    localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INSTR_SAMPLE = 3'h4;
    localparam logic [2:0] INSTR_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE_LSB = 2'h1;
    localparam logic IR_CAPTURE_MSB = 1'h0;
    localparam logic [2:0] IR_RESET = INSTR_IDCODE;

    localparam int ID_W = 32;
    localparam int ID_PART_LSB = 12;
    localparam int ID_VENDOR_LSB = 1;
    // Arbitrary part and vendor values
    localparam logic [19:0] ID_PART = 20'h5A5A5;
    localparam logic [10:0] ID_VENDOR = 11'h2AA;
    localparam logic ID_PRESENT = 1'h1;

    localparam int BSR_IN_W = 24;
    localparam int BSR_OUT_W = 18;
    localparam int BSR_FIX_W = 2;
    localparam int BSR_OUT_LSB = BSR_IN_W;
    localparam int BSR_FIX_LSB = BSR_IN_W + BSR_OUT_W;
    localparam int BSR_W = BSR_IN_W + BSR_OUT_W + BSR_FIX_W;
    localparam logic [BSR_FIX_W-1:0] BSR_FIX_VAL = 2'h3;

    localparam logic [2:0] TCK_SYNC_RESET = 3'h0;
    localparam logic [1:0] SER_SYNC_RESET = 2'h3;
    localparam logic BYPASS_RESET = 1'h0;
    localparam logic BYPASS_CAPTURE = 1'h0;
    localparam logic TDO_RESET = 1'h0;
    localparam logic TDO_OE_N_RESET = 1'h1;
    localparam logic HIZ_RESET = 1'h0;

    typedef enum logic [3:0] {
        ST_RESET,
        ST_IDLE,
        ST_SEL_DR,
        ST_CAP_DR,
        ST_SHIFT_DR,
        ST_EXIT1_DR,
        ST_PAUSE_DR,
        ST_EXIT2_DR,
        ST_UPD_DR,
        ST_SEL_IR,
        ST_CAP_IR,
        ST_SHIFT_IR,
        ST_EXIT1_IR,
        ST_PAUSE_IR,
        ST_EXIT2_IR,
        ST_UPD_IR
    } stap_state_t;

    typedef enum logic [1:0] {
        PATH_BYPASS,
        PATH_ID,
        PATH_BSR
    } stap_path_t;

    typedef struct packed {
        logic rise;
        logic fall;
        logic tms;
        logic tdi;
    } stap_link_t;

endpackage

// file: hw/stap_fsm.sv
`timescale 1ns/1ps
module stap_fsm (
    input wire logic clock_i,                        // System clock
    input wire logic rst_i,                          // Power-up reset
    input wire stap_pkg::stap_link_t link_i,         // Sampled link events
    output stap_pkg::stap_state_t state_o            // Current TAP state
);

    stap_pkg::stap_state_t next_state;
    logic tms;

    assign tms = link_i.tms;

    // Transitions advance on TCK rise only
    always_comb begin
        next_state = state_o;
        case (state_o)
            stap_pkg::ST_RESET: next_state = tms ? stap_pkg::ST_RESET : stap_pkg::ST_IDLE;
            stap_pkg::ST_IDLE: next_state = tms ? stap_pkg::ST_SEL_DR : stap_pkg::ST_IDLE;
            stap_pkg::ST_SEL_DR: next_state = tms ? stap_pkg::ST_SEL_IR : stap_pkg::ST_CAP_DR;
            stap_pkg::ST_CAP_DR: next_state = tms ? stap_pkg::ST_EXIT1_DR : stap_pkg::ST_SHIFT_DR;
            stap_pkg::ST_SHIFT_DR: next_state = tms ? stap_pkg::ST_EXIT1_DR : stap_pkg::ST_SHIFT_DR;
            stap_pkg::ST_EXIT1_DR: next_state = tms ? stap_pkg::ST_UPD_DR : stap_pkg::ST_PAUSE_DR;
            stap_pkg::ST_PAUSE_DR: next_state = tms ? stap_pkg::ST_EXIT2_DR : stap_pkg::ST_PAUSE_DR;
            stap_pkg::ST_EXIT2_DR: next_state = tms ? stap_pkg::ST_UPD_DR : stap_pkg::ST_SHIFT_DR;
            stap_pkg::ST_UPD_DR: next_state = tms ? stap_pkg::ST_SEL_DR : stap_pkg::ST_IDLE;
            stap_pkg::ST_SEL_IR: next_state = tms ? stap_pkg::ST_RESET : stap_pkg::ST_CAP_IR;
            stap_pkg::ST_CAP_IR: next_state = tms ? stap_pkg::ST_EXIT1_IR : stap_pkg::ST_SHIFT_IR;
            stap_pkg::ST_SHIFT_IR: next_state = tms ? stap_pkg::ST_EXIT1_IR : stap_pkg::ST_SHIFT_IR;
            stap_pkg::ST_EXIT1_IR: next_state = tms ? stap_pkg::ST_UPD_IR : stap_pkg::ST_PAUSE_IR;
            stap_pkg::ST_PAUSE_IR: next_state = tms ? stap_pkg::ST_EXIT2_IR : stap_pkg::ST_PAUSE_IR;
            stap_pkg::ST_EXIT2_IR: next_state = tms ? stap_pkg::ST_UPD_IR : stap_pkg::ST_SHIFT_IR;
            stap_pkg::ST_UPD_IR: next_state = tms ? stap_pkg::ST_SEL_DR : stap_pkg::ST_IDLE;
            default: next_state = stap_pkg::ST_RESET;
        endcase
    end

    // Power-up and five TMS-high rises both land in reset
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_o <= stap_pkg::ST_RESET; // R16
        end else if (link_i.rise) begin
            state_o <= next_state; // R20 R16
        end
    end

endmodule

// file: hw/stap_top.sv
`timescale 1ns/1ps
module stap_top (
    input wire logic clock_i,                                    // System clock, 200 MHz
    input wire logic rst_i,                                      // Power-up reset
    input wire logic tck_i,                                      // Test clock pin
    input wire logic tms_i,                                      // Test mode select pin
    input wire logic tdi_i,                                      // Test data in pin
    input wire logic [stap_pkg::BSR_IN_W-1:0] pin_state_i,       // Input and I/O pin levels
    input wire logic [stap_pkg::BSR_OUT_W-1:0] ram_q_i,          // Core output data
    output logic tdo_o,                                          // Test data out
    output logic tdo_oe_n_o,                                     // Low while TDO drives
    output logic [stap_pkg::BSR_OUT_W-1:0] ram_q_o,              // Data to output drivers
    output logic ram_q_hiz_o,                                    // Output drivers high-Z
    output logic [stap_pkg::IR_W-1:0] instr_o                    // Active instruction
);

    // Path that an instruction places between TDI and TDO
    function automatic stap_pkg::stap_path_t path_of(input logic [2:0] code);
        stap_pkg::stap_path_t p;
        p = stap_pkg::PATH_BYPASS; // R4 R19
        if (code == stap_pkg::INSTR_IDCODE) begin
            p = stap_pkg::PATH_ID; // R10
        end else if (code == stap_pkg::INSTR_EXTEST) begin
            p = stap_pkg::PATH_BSR;
        end else if (code == stap_pkg::INSTR_SAMPLE) begin
            p = stap_pkg::PATH_BSR; // R5
        end else if (code == stap_pkg::INSTR_SAMPLE_Z) begin
            p = stap_pkg::PATH_BSR; // R12
        end
        return p;
    endfunction

    // Instruction that hands the output drivers to the hold cells
    function automatic logic is_extest(input logic [2:0] code);
        return code == stap_pkg::INSTR_EXTEST;
    endfunction

    // Instruction that floats the output drivers
    function automatic logic is_float(input logic [2:0] code);
        return code == stap_pkg::INSTR_SAMPLE_Z;
    endfunction

    // Test clock edge seen while the TAP sits in one state
    function automatic logic tap_event(input logic seen, input stap_pkg::stap_state_t now,
                                       input stap_pkg::stap_state_t want);
        return seen && (now == want);
    endfunction

    // Pin synchronisers
    logic [2:0] tck_sync;
    logic [1:0] tms_sync;
    logic [1:0] tdi_sync;
    logic [stap_pkg::BSR_IN_W-1:0] pin_meta;
    logic [stap_pkg::BSR_IN_W-1:0] pin_sync;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tck_sync <= stap_pkg::TCK_SYNC_RESET;
        end else begin
            tck_sync <= {tck_sync[1:0], tck_i};
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tms_sync <= stap_pkg::SER_SYNC_RESET;
            tdi_sync <= stap_pkg::SER_SYNC_RESET;
        end else begin
            tms_sync <= {tms_sync[0], tms_i};
            tdi_sync <= {tdi_sync[0], tdi_i};
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_state_i;
            pin_sync <= pin_meta;
        end
    end

    stap_pkg::stap_link_t link;

    assign link.rise = tck_sync[1] & ~tck_sync[2];
    assign link.fall = ~tck_sync[1] & tck_sync[2];
    assign link.tms = tms_sync[1];
    assign link.tdi = tdi_sync[1];

    stap_pkg::stap_state_t state;

    stap_fsm u_fsm (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .link_i(link),
        .state_o(state)
    );

    // Test registers
    logic [stap_pkg::IR_W-1:0] ir_shift;
    logic [stap_pkg::ID_W-1:0] id_shift;
    logic [stap_pkg::BSR_W-1:0] bsr_shift;
    logic [stap_pkg::BSR_OUT_W-1:0] bsr_hold;
    logic bypass_bit;

    stap_pkg::stap_path_t path;

    assign path = path_of(instr_o);

    // State decode: capture, shift and update strobes qualified by TCK edges, then plain state levels
    wire cap_ir = tap_event(link.rise, state, stap_pkg::ST_CAP_IR);
    wire shift_ir = tap_event(link.rise, state, stap_pkg::ST_SHIFT_IR);
    wire upd_ir = tap_event(link.fall, state, stap_pkg::ST_UPD_IR);
    wire cap_dr = tap_event(link.rise, state, stap_pkg::ST_CAP_DR);
    wire shift_dr = tap_event(link.rise, state, stap_pkg::ST_SHIFT_DR);
    wire upd_dr = tap_event(link.fall, state, stap_pkg::ST_UPD_DR);
    wire in_reset = (state == stap_pkg::ST_RESET);
    wire in_shift_ir = (state == stap_pkg::ST_SHIFT_IR);
    wire in_shift_dr = (state == stap_pkg::ST_SHIFT_DR);

    wire sel_bsr = (path == stap_pkg::PATH_BSR);
    wire sel_id = (path == stap_pkg::PATH_ID);
    wire sel_byp = (path == stap_pkg::PATH_BYPASS);

    wire extest_now = is_extest(instr_o);
    wire extest_new = is_extest(ir_shift);
    wire samplez_now = is_float(instr_o);
    wire samplez_new = is_float(ir_shift);

    // Instruction shift register
    logic [stap_pkg::IR_W-1:0] ir_cap_val;
    logic [stap_pkg::IR_W-1:0] ir_shift_val;
    logic [stap_pkg::IR_W-1:0] next_ir_shift;

    assign ir_cap_val = {stap_pkg::IR_CAPTURE_MSB, stap_pkg::IR_CAPTURE_LSB}; // R1
    assign ir_shift_val = {link.tdi, ir_shift[stap_pkg::IR_W-1:1]}; // R2 R15
    assign next_ir_shift = cap_ir ? ir_cap_val :
                           shift_ir ? ir_shift_val :
                           ir_shift;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ir_shift <= stap_pkg::IR_RESET;
        end else begin
            ir_shift <= next_ir_shift;
        end
    end

    // Active instruction changes only at update or reset state
    logic [stap_pkg::IR_W-1:0] next_instr;

    assign next_instr = in_reset ? stap_pkg::IR_RESET : // R11
                        upd_ir ? ir_shift : // R3
                        instr_o;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            instr_o <= stap_pkg::IR_RESET; // R11
        end else begin
            instr_o <= next_instr;
        end
    end

    // Bypass flip-flop
    logic next_bypass;

    assign next_bypass = (cap_dr && sel_byp) ? stap_pkg::BYPASS_CAPTURE :
                         (shift_dr && sel_byp) ? link.tdi : // R17 R4
                         bypass_bit;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bypass_bit <= stap_pkg::BYPASS_RESET;
        end else begin
            bypass_bit <= next_bypass;
        end
    end

    // Identification register
    logic [stap_pkg::ID_W-1:0] id_value;
    logic [stap_pkg::ID_W-1:0] id_shifted;
    logic [stap_pkg::ID_W-1:0] next_id;

    assign id_value = {stap_pkg::ID_PART, stap_pkg::ID_VENDOR, stap_pkg::ID_PRESENT}; // R13
    assign id_shifted = {link.tdi, id_shift[stap_pkg::ID_W-1:1]}; // R18
    assign next_id = (cap_dr && sel_id) ? id_value : // R10
                     (shift_dr && sel_id) ? id_shifted :
                     id_shift;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            id_shift <= '0;
        end else begin
            id_shift <= next_id;
        end
    end

    // Boundary scan register: inputs low, outputs, then fixed cells
    logic [stap_pkg::BSR_W-1:0] bsr_cap_val;
    logic [stap_pkg::BSR_W-1:0] bsr_shifted;
    logic [stap_pkg::BSR_W-1:0] next_bsr;

    // Pins are only observed, never gated
    assign bsr_cap_val = {stap_pkg::BSR_FIX_VAL, ram_q_o, pin_sync}; // R6 R7 R9 R5
    assign bsr_shifted = {link.tdi, bsr_shift[stap_pkg::BSR_W-1:1]};
    assign next_bsr = (cap_dr && sel_bsr) ? bsr_cap_val : // R9 R5
                      (shift_dr && sel_bsr) ? bsr_shifted :
                      bsr_shift;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bsr_shift <= '0;
        end else begin
            bsr_shift <= next_bsr;
        end
    end

    // Output cells hold what external test drives
    logic [stap_pkg::BSR_OUT_W-1:0] bsr_out_cells;
    logic [stap_pkg::BSR_OUT_W-1:0] next_hold;
    logic hold_load;

    assign bsr_out_cells = bsr_shift[stap_pkg::BSR_OUT_LSB +: stap_pkg::BSR_OUT_W];
    assign hold_load = (upd_ir && extest_new) || (upd_dr && sel_bsr); // R8
    assign next_hold = hold_load ? bsr_out_cells : bsr_hold;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bsr_hold <= '0;
        end else begin
            bsr_hold <= next_hold;
        end
    end

    // RAM output drivers
    logic [stap_pkg::BSR_OUT_W-1:0] next_ram_q;
    logic next_hiz;
    logic extest_drive;

    // Extest takes effect at the same update edge that loads the hold cells
    assign extest_drive = upd_ir ? extest_new : extest_now;
    assign next_ram_q = extest_drive ? next_hold : ram_q_i; // R8 R9
    assign next_hiz = upd_ir ? samplez_new :
                      in_reset ? 1'h0 :
                      samplez_now; // R12

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ram_q_o <= '0;
            ram_q_hiz_o <= stap_pkg::HIZ_RESET;
        end else begin
            ram_q_o <= next_ram_q;
            ram_q_hiz_o <= next_hiz;
        end
    end

    // Serial output, updated on TCK fall
    logic dr_lsb;
    logic next_tdo;
    logic next_tdo_oe_n;

    assign dr_lsb = sel_id ? id_shift[0] : // R18
                    sel_bsr ? bsr_shift[0] :
                    bypass_bit;
    assign next_tdo = !link.fall ? tdo_o :
                      in_shift_ir ? ir_shift[0] : // R2
                      in_shift_dr ? dr_lsb :
                      tdo_o;
    assign next_tdo_oe_n = !link.fall ? tdo_oe_n_o :
                           !(in_shift_ir || in_shift_dr);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tdo_o <= stap_pkg::TDO_RESET;
            tdo_oe_n_o <= stap_pkg::TDO_OE_N_RESET;
        end else begin
            tdo_o <= next_tdo;
            tdo_oe_n_o <= next_tdo_oe_n;
        end
    end

endmodule

// file: verif/stap_jtag_model.sv
`timescale 1ns/1ps
module stap_jtag_model (
    output logic tck_o,      // Test clock, low between frames
    output logic tms_o,      // Mode select
    output logic tdi_o,      // Serial data to the device
    input wire logic tdo_i   // Resolved serial line
);
    initial begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h1;
    end

    // One 64 ns TCK period, TDO taken just before the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #16;
        tdo = tdo_i;
        tck_o = 1'h1;
        #16;
        tdi_o = 1'h1;
        #16;
        tck_o = 1'h0;
        #16;
    endtask

    task automatic reset_tap();
        logic d;
        repeat (5) step(1'h1, 1'h1, d);
        step(1'h0, 1'h1, d);
    endtask

    // Idle to idle scan of n bits, LSB first
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic d;
        dout = 64'h0;
        step(1'h1, 1'h1, d);
        if (ir) begin
            step(1'h1, 1'h1, d);
        end
        step(1'h0, 1'h1, d);
        step(1'h0, 1'h1, d);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
        step(1'h1, 1'h1, d);
        step(1'h0, 1'h1, d);
    endtask
endmodule

// file: verif/stap_top_asserts.sv
`timescale 1ns/1ps
module stap_top_asserts (
    input wire logic clock_i,                               // System clock
    input wire logic rst_i,                                 // Reset
    input wire logic tck_i,                                 // Test clock
    input wire logic tms_i,                                 // Mode select
    input wire logic tdi_i,                                 // Serial in
    input wire logic [stap_pkg::BSR_IN_W-1:0] pin_state_i,  // Pin levels
    input wire logic [stap_pkg::BSR_OUT_W-1:0] ram_q_i,     // Core data
    input wire logic tdo_o,                                 // Serial out
    input wire logic tdo_oe_n_o,                            // Serial out enable
    input wire logic [stap_pkg::BSR_OUT_W-1:0] ram_q_o,     // Driver data
    input wire logic ram_q_hiz_o,                           // Drivers floated
    input wire logic [stap_pkg::IR_W-1:0] instr_o           // Active instruction
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    // TCK seen low on the last two samples
    sequence s_after_fall;
        !tck_i && !$past(tck_i);
    endsequence

    a_instr_update: assert property ($changed(instr_o) && instr_o != stap_pkg::INSTR_IDCODE
        |-> s_after_fall) else $error("instruction changed outside a TCK fall");
    a_tdo_fall: assert property ($changed(tdo_o) |-> s_after_fall)
        else $error("TDO changed outside a TCK fall");
    a_oe_fall: assert property ($changed(tdo_oe_n_o) |-> s_after_fall)
        else $error("TDO enable changed outside a TCK fall");
    a_tdo_shift: assert property ($changed(tdo_o) |-> !tdo_oe_n_o)
        else $error("TDO changed while disabled");
    a_hiz_on: assert property ((instr_o == stap_pkg::INSTR_SAMPLE_Z)[*2] |-> ram_q_hiz_o)
        else $error("drivers not floated");
    a_hiz_off: assert property ((instr_o != stap_pkg::INSTR_SAMPLE_Z)[*2] |-> !ram_q_hiz_o)
        else $error("drivers floated by wrong instruction");
    a_q_follow: assert property ((instr_o != stap_pkg::INSTR_EXTEST)[*3]
        |-> ram_q_o == $past(ram_q_i)) else $error("driver data not following core");
    a_extest_hold: assert property (instr_o == stap_pkg::INSTR_EXTEST && $changed(ram_q_o)
        |-> s_after_fall) else $error("held driver data changed outside a TCK fall");
endmodule

bind stap_top stap_top_asserts chk_u (.clock_i(clock_i), .rst_i(rst_i), .tck_i(tck_i),
    .tms_i(tms_i), .tdi_i(tdi_i), .pin_state_i(pin_state_i), .ram_q_i(ram_q_i),
    .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o), .ram_q_o(ram_q_o),
    .ram_q_hiz_o(ram_q_hiz_o), .instr_o(instr_o));

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
    logic clock_i = 1'h0;
    logic rst_i = 1'h1;
    logic tck_i, tms_i, tdi_i, tdo_o, tdo_oe_n_o, ram_q_hiz_o, tdo_line;
    logic [23:0] pin_state_i = 24'h0;
    logic [17:0] ram_q_i = 18'h0;
    logic [17:0] ram_q_o;
    logic [2:0] instr_o;
    logic [63:0] got;
    logic [2:0] byp [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
    logic [63:0] fixh;
    int errors = 0;
    int cmp_count = 0;

    always #2.5 clock_i = ~clock_i;
    // Released TDO shows the inverse of its last value
    assign tdo_line = tdo_oe_n_o ? ~tdo_o : tdo_o;

    stap_top dut_u (.clock_i(clock_i), .rst_i(rst_i), .tck_i(tck_i), .tms_i(tms_i),
        .tdi_i(tdi_i), .pin_state_i(pin_state_i), .ram_q_i(ram_q_i), .tdo_o(tdo_o),
        .tdo_oe_n_o(tdo_oe_n_o), .ram_q_o(ram_q_o), .ram_q_hiz_o(ram_q_hiz_o),
        .instr_o(instr_o));
    stap_jtag_model ctl_u (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_line));

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask

    task automatic set_pins(input logic [23:0] p, input logic [17:0] q);
        @(posedge clock_i);
        #1.25;
        pin_state_i = p;
        ram_q_i = q;
        repeat (6) @(posedge clock_i);
        #1.25;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        $display("watchdog expired");
        give_verdict();
    end

    initial begin
        fixh = {20'h0, stap_pkg::BSR_FIX_VAL, 42'h0};
        repeat (8) @(posedge clock_i);
        #1.25;
        rst_i = 1'h0;
        repeat (4) @(posedge clock_i);
        #1.25;
        chk(64'(instr_o), 64'(stap_pkg::INSTR_IDCODE));
        chk(64'(tdo_oe_n_o), 64'h1);
        ctl_u.reset_tap();
        ctl_u.scan(1'h0, 32, 64'h0, got);
        chk(got, {32'h0, stap_pkg::ID_PART, stap_pkg::ID_VENDOR, stap_pkg::ID_PRESENT});
        chk(64'(got[0]), 64'h1);
        $display("test idcode done");

        foreach (byp[k]) begin
            ctl_u.scan(1'h1, 3, 64'(byp[k]), got);
            chk(got, {61'h0, stap_pkg::IR_CAPTURE_MSB, stap_pkg::IR_CAPTURE_LSB});
            chk(64'(instr_o), 64'(byp[k]));
            ctl_u.scan(1'h0, 8, 64'hC5, got);
            chk(got, 64'h8A);
            chk(64'(ram_q_hiz_o), 64'h0);
        end
        $display("test bypass done");

        set_pins(24'hA1B2C3, 18'h2D4E6);
        ctl_u.scan(1'h1, 3, 64'h4, got);
        ctl_u.scan(1'h0, 44, {20'h0, 2'h0, 18'h15A5A, 24'h0F0F0F}, got);
        chk(got, fixh | {22'h0, 18'h2D4E6, 24'hA1B2C3});
        chk(got & 64'hC0000000000, fixh);
        $display("test sample done");

        ctl_u.scan(1'h1, 3, 64'h0, got);
        chk(64'(ram_q_o), 64'h15A5A);
        set_pins(24'h5C3A96, 18'h3FFFF);
        chk(64'(ram_q_o), 64'h15A5A);
        ctl_u.scan(1'h0, 44, {20'h0, 2'h0, 18'h0ABCD, 24'h0}, got);
        chk(got, fixh | {22'h0, 18'h15A5A, 24'h5C3A96});
        chk(64'(ram_q_o), 64'h0ABCD);
        $display("test extest done");

        ctl_u.scan(1'h1, 3, 64'h2, got);
        chk(64'(ram_q_hiz_o), 64'h1);
        chk(64'(ram_q_o), 64'h3FFFF);
        ctl_u.scan(1'h0, 44, 64'h0, got);
        chk(got, fixh | {22'h0, 18'h3FFFF, 24'h5C3A96});
        ctl_u.reset_tap();
        chk(64'(instr_o), 64'(stap_pkg::INSTR_IDCODE));
        chk(64'(ram_q_hiz_o), 64'h0);
        $display("test float and reset done");
        give_verdict();
    end
endmodule
